//--- engine_start_gate_and_run_detect.sv
// What this block does
// - Starter stays off until the start condition reaches its level.
// - Default prepare: crank after prepare expiry and threshold reached.
// - Interrupting prepare: crank as soon as threshold is reached.
// - Threshold source multi-input 20, 21 or 22; 20 after reset.
// - Threshold set point 0.0 to 300.0, reset 0.0; met when input reaches it.
// - Secondary source running while primary silent at crank: starter held one extra second.
// - Any secondary running indication counts as a successful start.
// - Nothing running: sequence ends after delay 0.0 to 5.0 s.
// - Once running, status uses all running sources together.
// - Frequency running: 30.0 to 35.0 Hz, voltage at least 30 % nominal.
// - Stop, start failure, emergency stop, shutdown or trip-stop alarm abort.
// - Panel, bus and digital stop abort only in manual or operator mode.
// - Auto mode: dropped auto request aborts in island, fixed, take-over, export.
// - Block mode refused while the engine is running.
// - Pickup: teeth 0 to 500, speed 0 to 4000 RPM, reset 0 and 1000.
// - Primary source: digital, pickup, frequency, engine link, multi 20-23; frequency.
// - Prepare on at start, off at starter on; zero time disables.
// - Starter held off for the pause time between crank attempts.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`include "start_gate_cfg.svh"
`default_nettype none
module engine_start_gate_and_run_detect
    import start_gate_pkg::*;
#(
    parameter int TICK_CYCLES = `SEQ_TICK_NS / `CLK_PERIOD_NS,
    parameter int TW = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic start_cmd,
    input wire stop_evt_t stop_evt,
    input wire logic auto_start_req,
    input wire plant_mode_t plant_mode,
    input wire run_mode_t mode_sel,
    input wire logic mode_load,
    input wire logic [2:0][15:0] multi_val,
    input wire run_src_t run_in,
    input wire logic [15:0] freq_dhz,
    input wire logic [7:0] volt_pct,
    input wire logic [15:0] pickup_hz,
    output logic starter_out,
    output logic prepare_out,
    output logic running_out,
    output logic seq_active,
    output logic start_failed,
    output run_mode_t mode_out
);
    localparam int EXTRA_TICKS = `EXTRA_CRANK_MS / `SEQ_TICK_MS;

    seq_state_t state_reg, state_next;
    run_mode_t mode_reg, mode_next;
    logic refused_reg, refused_next;
    logic [23:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic prep_int_reg, prep_int_next;
    logic [1:0] thr_src_reg, thr_src_next;
    logic [2:0] prim_src_reg, prim_src_next;
    logic [TW-1:0] thresh_reg, thresh_next, prep_reg, prep_next, on_reg, on_next;
    logic [TW-1:0] off_reg, off_next, nr_reg, nr_next, teeth_reg, teeth_next;
    logic [TW-1:0] rpm_reg, rpm_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic starter_reg, prepare_reg, running_reg, active_reg, failed_reg;
    logic starter_next, prepare_next, running_next, active_next, failed_next;
    logic ld_prep, ld_on, ld_extra, ld_nr, ld_off;
    logic exp_prep, exp_on, exp_extra, exp_nr, exp_off;
    logic abort_evt, thr_ok, prim_run, sec_run, any_run, freq_run, pickup_run;
    logic [7:0] run_vec, prim_mask;

    function automatic logic [TW-1:0] clamp(input logic [31:0] v, input logic [TW-1:0] lo,
                                            input logic [TW-1:0] hi);
        return (v > 32'(hi)) ? hi : (v < 32'(lo)) ? lo : v[TW-1:0];
    endfunction

    // Running indications of every source.
    always_comb begin
        freq_run = (freq_dhz >= `FREQ_RUN_LO) && (freq_dhz <= `FREQ_RUN_HI)
                   && (volt_pct >= `VOLT_RUN_PCT);
        pickup_run = (teeth_reg != '0) && ({16'h0000, pickup_hz} * `SEC_PER_MIN
                     >= {16'h0000, rpm_reg} * {16'h0000, teeth_reg});
        run_vec = {run_in.multi, run_in.engine_comm_link, freq_run, pickup_run, run_in.dig};
        prim_mask = 8'h01 << prim_src_reg;
        prim_run = |(run_vec & prim_mask);
        sec_run = |(run_vec & ~prim_mask);
        any_run = |run_vec;
        thr_ok = multi_val[thr_src_reg] >= thresh_reg;
    end

    // Abort events, with stop commands and auto request qualified by mode.
    always_comb begin
        abort_evt = stop_evt.stop_signal | stop_evt.start_failure | stop_evt.estop
                    | stop_evt.alarm_shutdown | stop_evt.alarm_trip_stop;
        if (mode_reg inside {MODE_MANUAL, MODE_OPERATOR}
            && (stop_evt.panel_stop | stop_evt.bus_stop | stop_evt.dig_stop)) begin
            abort_evt = 1'b1;
        end
        if (mode_reg == MODE_AUTO && !auto_start_req
            && plant_mode inside {PLANT_ISLAND, PLANT_FIXED, PLANT_LTO, PLANT_EXPORT}) begin
            abort_evt = 1'b1;
        end
    end

    // Divider giving one tick every 0.1 s.
    always_comb begin
        tick_next = (tick_cnt_reg == 24'(TICK_CYCLES - 1));
        tick_cnt_next = tick_next ? 24'h000000 : tick_cnt_reg + 24'h000001;
    end

    // Sequence timers, each cleared by an abort unless loaded in the same cycle.
    tick_timer #(.W(TW)) u_prep (.clock(clock), .sys_rst(sys_rst), .clear(abort_evt),
        .load(ld_prep), .load_val(prep_reg), .tick(tick_reg), .expired(exp_prep));
    tick_timer #(.W(TW)) u_on (.clock(clock), .sys_rst(sys_rst), .clear(abort_evt),
        .load(ld_on), .load_val(on_reg), .tick(tick_reg), .expired(exp_on));
    tick_timer #(.W(TW)) u_extra (.clock(clock), .sys_rst(sys_rst), .clear(abort_evt),
        .load(ld_extra), .load_val(TW'(EXTRA_TICKS)), .tick(tick_reg), .expired(exp_extra));
    tick_timer #(.W(TW)) u_nr (.clock(clock), .sys_rst(sys_rst), .clear(abort_evt),
        .load(ld_nr), .load_val(nr_reg), .tick(tick_reg), .expired(exp_nr));
    tick_timer #(.W(TW)) u_off (.clock(clock), .sys_rst(sys_rst), .clear(abort_evt),
        .load(ld_off), .load_val(off_reg), .tick(tick_reg), .expired(exp_off));

    // Start sequencer: prepare, crank, extra crank, not-running wait, running.
    always_comb begin
        state_next = state_reg;
        {ld_prep, ld_on, ld_extra, ld_nr, ld_off} = 5'h00;
        failed_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_cmd && mode_reg != MODE_BLOCK && exp_off) begin
                    state_next = ST_PREP;
                    ld_prep = 1'b1;
                end
            end
            ST_PREP: begin
                if (thr_ok && (exp_prep || prep_int_reg)) begin
                    state_next = ST_CRANK;
                    ld_on = 1'b1;
                end
            end
            ST_CRANK: begin
                if (prim_run) begin
                    state_next = ST_RUN;
                end else if (sec_run) begin
                    state_next = ST_EXTRA;
                    ld_extra = 1'b1;
                end else if (exp_on) begin
                    state_next = ST_WAIT_NR;
                    ld_nr = 1'b1;
                end
            end
            ST_EXTRA: begin
                if (exp_extra) begin
                    if (any_run) begin
                        state_next = ST_RUN;
                    end else begin
                        state_next = ST_WAIT_NR;
                        ld_nr = 1'b1;
                    end
                end
            end
            ST_WAIT_NR: begin
                if (any_run) begin
                    state_next = ST_RUN;
                end else if (exp_nr) begin
                    state_next = ST_IDLE;
                    ld_off = 1'b1;
                    failed_next = 1'b1;
                end
            end
            ST_RUN: if (!any_run) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (abort_evt) begin
            state_next = ST_IDLE;
        end
        starter_next = (state_next == ST_CRANK) || (state_next == ST_EXTRA);
        prepare_next = (state_next == ST_PREP) && (prep_reg != '0);
        running_next = (state_next == ST_RUN);
        active_next = (state_next != ST_IDLE);
    end

    // Running mode; block requests are refused and flagged while running.
    always_comb begin
        mode_next = mode_reg;
        refused_next = refused_reg;
        if (wr_pend_reg && wr_addr_reg == `OFS_STATUS && hwdata[`STAT_REFUSED_BIT]) begin
            refused_next = 1'b0;
        end
        if (mode_load) begin
            if (mode_sel == MODE_BLOCK && (running_reg || any_run)) begin
                refused_next = 1'b1;
            end else begin
                mode_next = mode_sel;
            end
        end
    end

    // AHB-Lite slave: read data registered in the address phase, writes in the data phase.
    always_comb begin
        wr_pend_next = hsel && hready && htrans[1] && hwrite;
        wr_addr_next = wr_pend_next ? haddr[7:0] : wr_addr_reg;
        hrdata_next = hrdata_reg;
        if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata_next = 32'h00000000;
            case (haddr[7:0])
                `OFS_CTRL: begin
                    hrdata_next[`CTRL_PREP_INT_BIT] = prep_int_reg;
                    hrdata_next[`CTRL_THR_LSB +: 2] = thr_src_reg;
                    hrdata_next[`CTRL_PRIM_LSB +: 3] = prim_src_reg;
                end
                `OFS_THRESH: hrdata_next[TW-1:0] = thresh_reg;
                `OFS_PREP: hrdata_next[TW-1:0] = prep_reg;
                `OFS_ON: hrdata_next[TW-1:0] = on_reg;
                `OFS_OFF: hrdata_next[TW-1:0] = off_reg;
                `OFS_NOTRUN: hrdata_next[TW-1:0] = nr_reg;
                `OFS_TEETH: hrdata_next[TW-1:0] = teeth_reg;
                `OFS_RPM: hrdata_next[TW-1:0] = rpm_reg;
                `OFS_STATUS: hrdata_next[11:0] = {refused_reg, mode_reg, thr_ok, prim_run,
                    any_run, running_reg, prepare_reg, starter_reg, state_reg};
            endcase
        end
    end

    // Configuration registers, clamped to their legal ranges on write; a threshold source above 2 is ignored.
    always_comb begin
        prep_int_next = prep_int_reg;
        thr_src_next = thr_src_reg;
        prim_src_next = prim_src_reg;
        thresh_next = thresh_reg;
        prep_next = prep_reg;
        on_next = on_reg;
        off_next = off_reg;
        nr_next = nr_reg;
        teeth_next = teeth_reg;
        rpm_next = rpm_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `OFS_CTRL: begin
                    prep_int_next = hwdata[`CTRL_PREP_INT_BIT];
                    if (hwdata[`CTRL_THR_LSB +: 2] <= `MAX_THR_SRC) begin
                        thr_src_next = hwdata[`CTRL_THR_LSB +: 2];
                    end
                    prim_src_next = hwdata[`CTRL_PRIM_LSB +: 3];
                end
                `OFS_THRESH: thresh_next = clamp(hwdata, '0, `MAX_THRESH);
                `OFS_PREP: prep_next = clamp(hwdata, '0, `MAX_PREP);
                `OFS_ON: on_next = clamp(hwdata, `MIN_ON, `MAX_ON);
                `OFS_OFF: off_next = clamp(hwdata, `MIN_OFF, `MAX_OFF);
                `OFS_NOTRUN: nr_next = clamp(hwdata, '0, `MAX_NOTRUN);
                `OFS_TEETH: teeth_next = clamp(hwdata, '0, `MAX_TEETH);
                `OFS_RPM: rpm_next = clamp(hwdata, '0, `MAX_RPM);
                default: ;
            endcase
        end
    end

    // Holds every register of the block outside the five timers.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b0;
            state_reg <= ST_IDLE;
            starter_reg <= 1'b0;
            prepare_reg <= 1'b0;
            running_reg <= 1'b0;
            active_reg <= 1'b0;
            failed_reg <= 1'b0;
            mode_reg <= MODE_MANUAL;
            refused_reg <= 1'b0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            prep_int_reg <= 1'b0;
            thr_src_reg <= `RST_THR_SRC;
            prim_src_reg <= `RST_PRIM_SRC;
            thresh_reg <= `RST_THRESH;
            prep_reg <= `RST_PREP;
            on_reg <= `RST_ON;
            off_reg <= `RST_OFF;
            nr_reg <= `RST_NOTRUN;
            teeth_reg <= `RST_TEETH;
            rpm_reg <= `RST_RPM;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            state_reg <= state_next;
            starter_reg <= starter_next;
            prepare_reg <= prepare_next;
            running_reg <= running_next;
            active_reg <= active_next;
            failed_reg <= failed_next;
            mode_reg <= mode_next;
            refused_reg <= refused_next;
            hreadyout <= 1'b1;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            prep_int_reg <= prep_int_next;
            thr_src_reg <= thr_src_next;
            prim_src_reg <= prim_src_next;
            thresh_reg <= thresh_next;
            prep_reg <= prep_next;
            on_reg <= on_next;
            off_reg <= off_next;
            nr_reg <= nr_next;
            teeth_reg <= teeth_next;
            rpm_reg <= rpm_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign starter_out = starter_reg;
    assign prepare_out = prepare_reg;
    assign running_out = running_reg;
    assign seq_active = active_reg;
    assign start_failed = failed_reg;
    assign mode_out = mode_reg;
endmodule
`default_nettype wire

//--- start_gate_cfg.svh
`ifndef START_GATE_CFG_SVH
`define START_GATE_CFG_SVH

// Clock and sequence tick timing.
`define CLK_PERIOD_NS 10
`define SEQ_TICK_NS 100000000
`define EXTRA_CRANK_MS 1000
`define SEQ_TICK_MS 100

// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_THRESH 8'h04
`define OFS_PREP 8'h08
`define OFS_ON 8'h0C
`define OFS_OFF 8'h10
`define OFS_NOTRUN 8'h14
`define OFS_TEETH 8'h18
`define OFS_RPM 8'h1C
`define OFS_STATUS 8'h20

// Control and status register field positions.
`define CTRL_PREP_INT_BIT 0
`define CTRL_THR_LSB 1
`define CTRL_PRIM_LSB 4
`define STAT_REFUSED_BIT 11

// Reset values; times and threshold in 0.1 units.
`define RST_THR_SRC 2'h0
`define RST_PRIM_SRC 3'h2
`define RST_THRESH 16'h0000
`define RST_PREP 16'h0032
`define RST_ON 16'h0032
`define RST_OFF 16'h0032
`define RST_NOTRUN 16'h0000
`define RST_TEETH 16'h0000
`define RST_RPM 16'h03E8

// Legal ranges.
`define MAX_THR_SRC 2'h2
`define MAX_THRESH 16'h0BB8
`define MAX_PREP 16'h1770
`define MIN_ON 16'h000A
`define MAX_ON 16'h1770
`define MIN_OFF 16'h000A
`define MAX_OFF 16'h03DE
`define MAX_NOTRUN 16'h0032
`define MAX_TEETH 16'h01F4
`define MAX_RPM 16'h0FA0

// Frequency running window in 0.1 Hz and voltage floor in percent.
`define FREQ_RUN_LO 16'h012C
`define FREQ_RUN_HI 16'h015E
`define VOLT_RUN_PCT 8'h1E
`define SEC_PER_MIN 32'h0000003C

`endif

//--- start_gate_pkg.sv
`default_nettype none
package start_gate_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PREP = 3'b001,
        ST_CRANK = 3'b010,
        ST_EXTRA = 3'b011,
        ST_WAIT_NR = 3'b100,
        ST_RUN = 3'b101
    } seq_state_t;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_OPERATOR = 2'b01,
        MODE_AUTO = 2'b10,
        MODE_BLOCK = 2'b11
    } run_mode_t;

    typedef enum logic [2:0] {
        PLANT_ISLAND = 3'b000,
        PLANT_FIXED = 3'b001,
        PLANT_LTO = 3'b010,
        PLANT_EXPORT = 3'b011,
        PLANT_PEAK = 3'b100,
        PLANT_MAINS_FAIL = 3'b101
    } plant_mode_t;

    // Running indications; bit index equals the primary source code.
    typedef struct packed {
        logic [3:0] multi;
        logic engine_comm_link;
        logic freq;
        logic speed_pickup;
        logic dig;
    } run_src_t;

    // Events that may end a start sequence.
    typedef struct packed {
        logic stop_signal;
        logic start_failure;
        logic estop;
        logic alarm_shutdown;
        logic alarm_trip_stop;
        logic panel_stop;
        logic bus_stop;
        logic dig_stop;
    } stop_evt_t;

endpackage
`default_nettype wire

//--- tick_timer.sv
`default_nettype none
module tick_timer #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // Load wins over clear so a timer loaded in the same cycle as an abort survives.
    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val;
        end else if (clear) begin
            cnt_next = '0;
        end else if (tick && cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = (cnt_reg == '0);
endmodule
`default_nettype wire

//--- engine_start_gate_and_run_detect_asserts.sv
`default_nettype none
module start_gate_asserts
    import start_gate_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire stop_evt_t stop_evt,
    input wire logic auto_start_req,
    input wire plant_mode_t plant_mode,
    input wire run_mode_t mode_sel,
    input wire logic mode_load,
    input wire logic starter_out,
    input wire logic prepare_out,
    input wire logic running_out,
    input wire logic seq_active,
    input wire logic start_failed,
    input wire run_mode_t mode_out
);
    logic hard_stop, alarm_stop, local_stop, auto_drop;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Abort causes grouped by how the mode qualifies them.
    assign hard_stop = stop_evt.stop_signal | stop_evt.estop;
    assign alarm_stop = stop_evt.alarm_shutdown | stop_evt.alarm_trip_stop | stop_evt.start_failure;
    assign local_stop = (stop_evt.panel_stop | stop_evt.bus_stop | stop_evt.dig_stop)
        & (mode_out inside {MODE_MANUAL, MODE_OPERATOR});
    assign auto_drop = mode_out == MODE_AUTO && !auto_start_req && plant_mode <= PLANT_EXPORT;

    chk_idle_quiet: assert property (!seq_active |-> !starter_out && !prepare_out)
        else $error("Relay output on while idle.");
    chk_prep_drop: assert property ($rose(starter_out) |-> !prepare_out)
        else $error("Prepare output still on at crank.");
    chk_stop_abort: assert property (seq_active && hard_stop |=> !seq_active && !starter_out)
        else $error("Stop or emergency stop did not abort.");
    chk_alarm_abort: assert property (seq_active && alarm_stop |=> !seq_active)
        else $error("Alarm or failure did not abort.");
    chk_local_abort: assert property (seq_active && local_stop |=> !seq_active)
        else $error("Local stop did not abort.");
    chk_auto_drop: assert property (seq_active && auto_drop |=> !seq_active)
        else $error("Dropped auto request did not abort.");
    chk_block_refused: assert property (
        mode_load && mode_sel == MODE_BLOCK && running_out |=> mode_out == $past(mode_out))
        else $error("Block mode entered while running.");
    chk_fail_pulse: assert property (start_failed |=> !start_failed && !seq_active)
        else $error("Start failure not a single pulse.");
endmodule

bind engine_start_gate_and_run_detect start_gate_asserts chk_i (
    .clock(clock), .sys_rst(sys_rst), .stop_evt(stop_evt), .auto_start_req(auto_start_req),
    .plant_mode(plant_mode), .mode_sel(mode_sel), .mode_load(mode_load),
    .starter_out(starter_out), .prepare_out(prepare_out), .running_out(running_out),
    .seq_active(seq_active), .start_failed(start_failed), .mode_out(mode_out)
);
`default_nettype wire

//--- engine_model.sv
`default_nettype none
module engine_model
    import start_gate_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic starter_out,
    input wire logic [1:0] behave,
    output logic [15:0] freq_dhz,
    output logic [7:0] volt_pct,
    output logic [15:0] pickup_hz,
    output run_src_t run_in
);
    logic [4:0] crank_reg, crank_next;
    logic fired_reg, fired_next;

    // Fires after twenty cranking cycles; runs until behave is zero.
    always_comb begin
        crank_next = crank_reg;
        fired_next = fired_reg | (crank_reg == 5'h14);
        if (behave == 2'h0) begin
            crank_next = 5'h00;
            fired_next = 1'b0;
        end else if (starter_out && crank_reg != 5'h14) begin
            crank_next = crank_reg + 5'h01;
        end
    end

    // Registers the cranking state.
    always_ff @(posedge clock) begin
        crank_reg <= sys_rst ? 5'h00 : crank_next;
        fired_reg <= sys_rst ? 1'b0 : fired_next;
    end

    // Behave 1 gives 32.0 Hz at 50 %, 3 the same with 20 % voltage, 2 the digital input only.
    assign freq_dhz = (fired_reg && behave[0]) ? 16'h0140 : 16'h0000;
    assign volt_pct = !fired_reg ? 8'h00 : (behave == 2'h1) ? 8'h32 : 8'h14;
    assign pickup_hz = 16'h0000;
    assign run_in = {7'h00, fired_reg && behave == 2'h2};
endmodule
`default_nettype wire

//--- tb_engine_start_gate_and_run_detect.sv
`include "start_gate_cfg.svh"
`default_nettype none
module tb_engine_start_gate_and_run_detect
    import start_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] RADR [9] = '{`OFS_CTRL, `OFS_THRESH, `OFS_PREP, `OFS_ON, `OFS_OFF,
        `OFS_NOTRUN, `OFS_TEETH, `OFS_RPM, 8'h40};
    localparam logic [15:0] RVAL [9] = '{16'h0020, 16'h0000, 16'h0032, 16'h0032, 16'h0032,
        16'h0000, 16'h0000, 16'h03E8, 16'h0000};
    localparam logic [7:0] CADR [3] = '{`OFS_THRESH, `OFS_RPM, `OFS_NOTRUN};
    localparam logic [15:0] CVAL [3] = '{16'h0BB8, 16'h0FA0, 16'h0032};
    logic clock, hresp, hreadyout, starter_out, prepare_out, running_out, seq_active;
    logic sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, start_cmd = 1'b0, mode_load = 1'b0;
    logic auto_start_req = 1'b1, start_failed;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
    logic [1:0] htrans = 2'h0, behave = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [2:0][15:0] multi_val = '0;
    logic [15:0] freq_dhz, pickup_hz;
    logic [7:0] volt_pct;
    stop_evt_t stop_evt = '0;
    plant_mode_t plant_mode = PLANT_ISLAND;
    run_mode_t mode_sel = MODE_MANUAL, mode_out;
    run_src_t run_in;
    int num_errors = 0, num_checks = 0, took;

    engine_start_gate_and_run_detect #(.TICK_CYCLES(10)) uut (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .start_cmd(start_cmd),
        .stop_evt(stop_evt), .auto_start_req(auto_start_req), .plant_mode(plant_mode),
        .mode_sel(mode_sel), .mode_load(mode_load), .multi_val(multi_val), .run_in(run_in),
        .freq_dhz(freq_dhz), .volt_pct(volt_pct), .pickup_hz(pickup_hz),
        .starter_out(starter_out), .prepare_out(prepare_out), .running_out(running_out),
        .seq_active(seq_active), .start_failed(start_failed), .mode_out(mode_out));
    engine_model eng (.clock(clock), .sys_rst(sys_rst), .starter_out(starter_out),
        .behave(behave), .freq_dhz(freq_dhz), .volt_pct(volt_pct), .pickup_hz(pickup_hz),
        .run_in(run_in));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Bounded wait: 0 starter, 1 running, 2 failure, 3 idle, 4 ready.
    task automatic wait_on(input int sel, input int lim);
        logic [4:0] v;
        logic hit;
        hit = 1'b0;
        took = 0;
        while (!hit && took < lim) begin
            @(posedge clock);
            took++;
            v = {hreadyout, !seq_active, start_failed, running_out, starter_out};
            hit = v[sel] === 1'b1;
        end
        check(hit, 1'b1);
        if (!hit) report_and_stop();
    endtask

    // One AHB-Lite single-word transfer.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_on(4, 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_on(4, 20);
        rdata = hrdata;
    endtask

    task automatic kick();
        start_cmd <= 1'b1;
        cyc(1);
        start_cmd <= 1'b0;
        cyc(2);
    endtask

    task automatic set_mode(input run_mode_t m);
        mode_sel <= m;
        mode_load <= 1'b1;
        cyc(1);
        mode_load <= 1'b0;
        cyc(2);
    endtask

    // Reset values, unmapped read, clamping.
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, RADR[i], 32'h0);
            check(rdata, {16'h0, RVAL[i]});
        end
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CADR[i], 32'h0000FFFF);
            bus(1'b0, CADR[i], 32'h0);
            check(rdata, {16'h0, CVAL[i]});
        end
        $display("t_regs done");
    endtask

    // Default prepare: crank only at threshold, run on frequency.
    task automatic t_default();
        bus(1'b1, `OFS_THRESH, 32'h64);
        behave <= 2'h1;
        kick();
        check({seq_active, prepare_out}, 2'h3);
        cyc(600);
        check(starter_out, 1'b0);
        multi_val[0] <= 16'h0064;
        wait_on(0, 20);
        check(prepare_out, 1'b0);
        wait_on(1, 100);
        behave <= 2'h0;
        wait_on(3, 20);
        $display("t_default done");
    endtask

    // Interrupt mode on input 21, then start on a secondary source only.
    task automatic t_secondary();
        bus(1'b1, `OFS_CTRL, 32'h23);
        multi_val[0] <= 16'h0000;
        multi_val[1] <= 16'h0064;
        behave <= 2'h2;
        kick();
        wait_on(0, 30);
        cyc(60);
        check({starter_out, running_out}, 2'h2);
        wait_on(1, 150);
        cyc(20);
        check(running_out, 1'b1);
        set_mode(MODE_AUTO);
        set_mode(MODE_BLOCK);
        check(mode_out, MODE_AUTO);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rdata[11], 1'b1);
        stop_evt.panel_stop <= 1'b1;
        cyc(5);
        check(running_out, 1'b1);
        auto_start_req <= 1'b0;
        cyc(2);
        check(seq_active, 1'b0);
        stop_evt <= '0;
        auto_start_req <= 1'b1;
        behave <= 2'h0;
        set_mode(MODE_MANUAL);
        $display("t_secondary done");
    endtask

    // Every abort event ends a sequence held in prepare in manual mode.
    task automatic t_aborts();
        multi_val <= '0;
        for (int i = 0; i < 8; i++) begin
            kick();
            check(seq_active, 1'b1);
            stop_evt <= stop_evt_t'(8'h01 << i);
            cyc(2);
            check({seq_active, starter_out, prepare_out}, 3'h0);
            stop_evt <= '0;
            cyc(1);
        end
        $display("t_aborts done");
    endtask

    // Low voltage: no frequency run; failure, then pause blocks restart.
    task automatic t_notrun();
        bus(1'b1, `OFS_CTRL, 32'h21);
        bus(1'b1, `OFS_ON, 32'h0A);
        bus(1'b1, `OFS_NOTRUN, 32'h0A);
        multi_val[0] <= 16'h0064;
        behave <= 2'h3;
        kick();
        wait_on(0, 30);
        wait_on(2, 400);
        check(took >= 170 && took <= 215, 1'b1);
        check(running_out, 1'b0);
        kick();
        check(seq_active, 1'b0);
        $display("t_notrun done");
    endtask

    // Reset for two cycles, then run the scenarios in turn.
    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        cyc(1);
        t_regs();
        t_default();
        t_secondary();
        t_aborts();
        t_notrun();
        report_and_stop();
    end
endmodule
`default_nettype wire
